// file: sjbfc_pkg.sv
/*
 * sjbfc_pkg: constants, register map and carrier structs for the serial job
 * buffer with flow control.
 * assumes: aclk at 100 MHz, one AXI4-Lite slave port, 32-bit data.
 */
package sjbfc_pkg;

	// byte counts, 1K = 1024
	localparam int unsigned KB            = 1024;
	localparam int unsigned BUF_BYTES     = 64 * KB;
	localparam int unsigned NEAR_FULL_LVL = 62 * KB;
	localparam int unsigned AVAIL_LVL     = 56 * KB;
	localparam int unsigned CNT_W         = 17;

	// timing
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned XON_REPEAT_MS = 5;
	localparam int unsigned XON_REPEAT_CYC = CLK_HZ / 1000 * XON_REPEAT_MS;
	localparam int unsigned BAUD_2400_DIV  = CLK_HZ / (2400 * 16);
	localparam int unsigned BAUD_4800_DIV  = CLK_HZ / (4800 * 16);
	localparam int unsigned BAUD_9600_DIV  = CLK_HZ / (9600 * 16);
	localparam int unsigned BAUD_19200_DIV = CLK_HZ / (19200 * 16);

	// flow characters
	localparam logic [7:0] CHAR_XON  = 8'h11;
	localparam logic [7:0] CHAR_XOFF = 8'h13;

	// register byte addresses
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_RXDATA = 8'h08;
	localparam logic [7:0] REG_LEVEL  = 8'h0C;

	// control field positions
	localparam int unsigned CTRL_MULTI  = 0;
	localparam int unsigned CTRL_SWFLOW = 1;
	localparam int unsigned CTRL_BAUD   = 2;
	localparam int unsigned CTRL_DATA7  = 4;
	localparam int unsigned CTRL_PAR_EN = 5;
	localparam int unsigned CTRL_PAR_OD = 6;
	localparam int unsigned CTRL_STOP2  = 7;
	localparam int unsigned CTRL_ONLINE = 8;
	localparam int unsigned CTRL_PRINT  = 9;
	localparam int unsigned CTRL_ERROR  = 10;
	localparam int unsigned CTRL_HEAD   = 11;
	localparam int unsigned CTRL_W      = 12;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h101;

	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef enum logic [1:0] {SJBFC_RX_IDLE, SJBFC_RX_BITS, SJBFC_RX_STOP} sjbfc_rx_e;
	typedef enum logic [1:0] {SJBFC_TX_IDLE, SJBFC_TX_SHIFT} sjbfc_tx_e;

	typedef struct packed {
		logic       dtr;
		logic       rts;
		logic       txd;
	} sjbfc_pins_out_s;

	typedef struct packed {
		logic       rxd;
		logic       cts;
		logic       dsr;
	} sjbfc_pins_in_s;

endpackage : sjbfc_pkg

// file: sjbfc_top.sv
/*
 * sjbfc_top: serial receive port with job buffer, hardware or character
 * flow control and an AXI4-Lite register slave.
 * assumes: host drives rxd/cts/dsr asynchronously; software reads received
 * bytes from the data register and reports printing, errors and on-line state.
 */
`timescale 1ns/10ps
// Overview of operation
// - single-job or queued-jobs mode; queue drains strictly first in first out
// - queued mode keeps receiving while earlier jobs print
// - flow control via ready line or X-On/X-Off characters as configured
// - empty buffer, on-line, no error and no single job printing signals ready
// - fill reaching 62K enters near-full and signals busy
// - queued mode: busy holds until fill drains to 56K, then ready again; single-job mode waits for an empty buffer
// - any printer error forces busy until cleared and back on-line
// - going off-line forces busy
// - bit rate selectable 2400, 4800, 9600 or 19200
// - one start bit, 7 or 8 data, parity option, 1 or 2 stop
// - transmit line carries only flow characters toward the host
// - ready-line mode: RTS low on head open or, while on-line, error while printing
// - bytes refused while CTS low
// - ready-line mode: DTR low when off-line or while a single job prints
// - ready-line mode: DTR high means ready, low means busy
// - ready character 0x11, busy character 0x13
// - character mode repeats X-On every 5 ms until first host byte
module sjbfc_top #(
	parameter int unsigned XON_CYC = sjbfc_pkg::XON_REPEAT_CYC
) (
	// clock and reset
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	// axi4-lite write
	input  wire logic [7:0]               s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]               s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	// serial pins
	input  wire sjbfc_pkg::sjbfc_pins_in_s pins_in,
	output sjbfc_pkg::sjbfc_pins_out_s     pins_out
);

	typedef struct packed {
		logic [1:0]                  sync_a;
		logic [1:0]                  sync_b;
		logic [1:0]                  sync_c;
		logic [sjbfc_pkg::CTRL_W-1:0] ctrl;
		logic                        aw_got;
		logic                        w_got;
		logic [7:0]                  aw_addr;
		logic [31:0]                 wdata;
		logic [3:0]                  wstrb;
		logic                        bvalid;
		logic [1:0]                  bresp;
		logic                        rvalid;
		logic [1:0]                  rresp;
		logic [31:0]                 rdata;
		logic [11:0]                 tick_cnt;
		logic                        tick;
		sjbfc_pkg::sjbfc_rx_e        rx_st;
		logic [3:0]                  rx_sub;
		logic [3:0]                  rx_bit;
		logic [10:0]                 rx_sh;
		logic                        overrun;
		logic                        frame_err;
		logic [7:0]                  mem_wr_data;
		logic                        mem_wr;
		logic [15:0]                 wr_ptr;
		logic [15:0]                 rd_ptr;
		logic [sjbfc_pkg::CNT_W-1:0] fill;
		logic                        near_full;
		logic                        busy_sent;
		logic                        hold_sent;
		logic                        first_rx;
		logic [22:0]                 rep_cnt;
		sjbfc_pkg::sjbfc_tx_e        tx_st;
		logic [3:0]                  tx_sub;
		logic [3:0]                  tx_bit;
		logic [9:0]                  tx_sh;
		logic                        txd;
		logic                        dtr;
		logic                        rts;
	} sjbfc_state_s;

	sjbfc_state_s st;
	sjbfc_state_s next_st;
	logic [7:0]   mem [0:sjbfc_pkg::BUF_BYTES-1];
	logic [7:0]   mem_q;

	// storage kept outside the state struct; too wide for one packed vector
	always_ff @(posedge aclk) begin
		if (st.mem_wr) begin
			mem[st.wr_ptr] <= st.mem_wr_data;
		end
		mem_q <= mem[st.rd_ptr];
	end

	logic rxd_s, cts_s, dsr_s;
	assign rxd_s = st.sync_a[1];
	assign cts_s = st.sync_b[1];
	assign dsr_s = st.sync_c[1];

	always_comb begin
		logic                        multi, swflow, data7, par_en, par_odd, stop2;
		logic                        online, printing, error, head;
		logic [11:0]                 div;
		logic                        wr_do, rd_do, pop, push, busy, want_busy;
		logic [3:0]                  nbits;
		logic [7:0]                  byte_v;
		next_st  = st;
		multi    = st.ctrl[sjbfc_pkg::CTRL_MULTI];
		swflow   = st.ctrl[sjbfc_pkg::CTRL_SWFLOW];
		data7    = st.ctrl[sjbfc_pkg::CTRL_DATA7];
		par_en   = st.ctrl[sjbfc_pkg::CTRL_PAR_EN];
		par_odd  = st.ctrl[sjbfc_pkg::CTRL_PAR_OD];
		stop2    = st.ctrl[sjbfc_pkg::CTRL_STOP2];
		online   = st.ctrl[sjbfc_pkg::CTRL_ONLINE];
		printing = st.ctrl[sjbfc_pkg::CTRL_PRINT];
		error    = st.ctrl[sjbfc_pkg::CTRL_ERROR];
		head     = st.ctrl[sjbfc_pkg::CTRL_HEAD];
		pop      = 1'b0;
		push     = 1'b0;
		byte_v   = 8'h00;
		nbits    = 4'h0;
		div      = 12'h000;
		wr_do    = 1'b0;
		rd_do    = 1'b0;
		busy     = 1'b0;
		want_busy = 1'b0;
		next_st.mem_wr = 1'b0;
		next_st.sync_a = {st.sync_a[0], pins_in.rxd};
		next_st.sync_b = {st.sync_b[0], pins_in.cts};
		next_st.sync_c = {st.sync_c[0], pins_in.dsr};

		// 16x oversampling tick
		unique case (st.ctrl[sjbfc_pkg::CTRL_BAUD +: 2])
			2'h0: div = 12'(sjbfc_pkg::BAUD_2400_DIV);
			2'h1: div = 12'(sjbfc_pkg::BAUD_4800_DIV);
			2'h2: div = 12'(sjbfc_pkg::BAUD_9600_DIV);
			2'h3: div = 12'(sjbfc_pkg::BAUD_19200_DIV);
		endcase
		next_st.tick = 1'b0;
		if (st.tick_cnt >= div - 12'h001) begin
			next_st.tick_cnt = 12'h000;
			next_st.tick     = 1'b1;
		end else begin
			next_st.tick_cnt = st.tick_cnt + 12'h001;
		end

		// axi write
		if (s_axi_awvalid && !st.aw_got) begin
			next_st.aw_got  = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st.w_got) begin
			next_st.w_got = 1'b1;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
		end
		wr_do = st.aw_got && st.w_got && !st.bvalid;
		if (wr_do) begin
			next_st.aw_got = 1'b0;
			next_st.w_got  = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp  = sjbfc_pkg::AXI_OKAY;
			if (st.aw_addr[7:2] == sjbfc_pkg::REG_CTRL[7:2]) begin
				if (st.wstrb[0]) next_st.ctrl[7:0] = st.wdata[7:0];
				if (st.wstrb[1]) next_st.ctrl[11:8] = st.wdata[11:8];
			end else if (st.aw_addr[7:2] == sjbfc_pkg::REG_STATUS[7:2]) begin
				if (st.wstrb[0] && st.wdata[4]) next_st.overrun = 1'b0;
				if (st.wstrb[0] && st.wdata[5]) next_st.frame_err = 1'b0;
			end else begin
				next_st.bresp = sjbfc_pkg::AXI_SLVERR;
			end
		end
		if (st.bvalid && s_axi_bready) next_st.bvalid = 1'b0;

		// axi read; data register read pops one byte in arrival order
		rd_do = s_axi_arvalid && !st.rvalid;
		if (rd_do) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = sjbfc_pkg::AXI_OKAY;
			unique case (s_axi_araddr[7:2])
				sjbfc_pkg::REG_CTRL[7:2]:   next_st.rdata = 32'(st.ctrl);
				sjbfc_pkg::REG_STATUS[7:2]: next_st.rdata = {26'h0, st.frame_err,
					st.overrun, st.near_full, st.fill == '0, st.dtr, st.rts};
				sjbfc_pkg::REG_RXDATA[7:2]: begin
					next_st.rdata = {23'h0, st.fill != '0, mem_q};
					pop = st.fill != '0;
				end
				sjbfc_pkg::REG_LEVEL[7:2]:  next_st.rdata = 32'(st.fill);
				default: begin
					next_st.rdata = 32'h0000_0000;
					next_st.rresp = sjbfc_pkg::AXI_SLVERR;
				end
			endcase
		end
		if (st.rvalid && s_axi_rready) next_st.rvalid = 1'b0;

		// receiver
		nbits = data7 ? 4'h7 : 4'h8;
		if (par_en) nbits = nbits + 4'h1;
		if (st.tick) begin
			unique case (st.rx_st)
				sjbfc_pkg::SJBFC_RX_IDLE: begin
					if (!rxd_s) begin
						next_st.rx_sub = st.rx_sub + 4'h1;
						if (st.rx_sub == 4'h7) begin
							next_st.rx_sub = 4'h0;
							next_st.rx_bit = 4'h0;
							next_st.rx_st  = sjbfc_pkg::SJBFC_RX_BITS;
						end
					end else begin
						next_st.rx_sub = 4'h0;
					end
				end
				sjbfc_pkg::SJBFC_RX_BITS: begin
					next_st.rx_sub = st.rx_sub + 4'h1;
					if (st.rx_sub == 4'hF) begin
						next_st.rx_sh  = {rxd_s, st.rx_sh[10:1]};
						next_st.rx_bit = st.rx_bit + 4'h1;
						if (st.rx_bit == nbits - 4'h1) next_st.rx_st = sjbfc_pkg::SJBFC_RX_STOP;
					end
				end
				sjbfc_pkg::SJBFC_RX_STOP: begin
					// only the first stop bit is checked; a second is idle time
					next_st.rx_sub = st.rx_sub + 4'h1;
					if (st.rx_sub == 4'hF) begin
						next_st.rx_st  = sjbfc_pkg::SJBFC_RX_IDLE;
						next_st.rx_sub = 4'h0;
						// data sits at the top of the shifter; lsb lands at bit 0
						byte_v = 8'(st.rx_sh >> (4'hB - nbits));
						if (data7) byte_v[7] = 1'b0;
						if (!rxd_s || (par_en && ((^(st.rx_sh >> (4'hB - nbits))) != par_odd))) begin
							next_st.frame_err = 1'b1;
						end else if (!cts_s || !dsr_s) begin
							// refused byte is simply dropped
						end else if (st.fill == 17'(sjbfc_pkg::BUF_BYTES)) begin
							next_st.overrun = 1'b1;
						end else begin
							push = 1'b1;
							next_st.first_rx = 1'b1;
						end
					end
				end
			endcase
		end
		if (push) begin
			next_st.mem_wr      = 1'b1;
			next_st.mem_wr_data = byte_v;
		end
		if (st.mem_wr) next_st.wr_ptr = st.wr_ptr + 16'h0001;
		if (pop) next_st.rd_ptr = st.rd_ptr + 16'h0001;
		next_st.fill = st.fill + 17'(st.mem_wr) - 17'(pop);

		// thresholds with hysteresis
		if (next_st.fill >= 17'(sjbfc_pkg::NEAR_FULL_LVL)) begin
			next_st.near_full = 1'b1;
		end else if (next_st.fill <= 17'(sjbfc_pkg::AVAIL_LVL)) begin
			next_st.near_full = 1'b0;
		end

		// busy decision
		// open head counts as an error: no printing, so no accepting either
		busy = !online || error || head;
		if (multi) begin
			busy = busy || st.near_full;
		end else begin
			busy = busy || printing || st.fill != '0;
		end
		next_st.dtr = swflow ? 1'b1 : !busy;
		next_st.rts = !(swflow ? 1'b0 : (head || (error && printing)));
		if (!online && !swflow) next_st.rts = st.rts && !head;
		if (head && !swflow) next_st.rts = 1'b0;

		// character flow: send on change, repeat X-On until first host byte
		want_busy = busy;
		if (!multi && error && printing) want_busy = 1'b1;
		next_st.hold_sent = 1'b0;
		if (st.rep_cnt != 23'h0) next_st.rep_cnt = st.rep_cnt - 23'h000001;
		if (swflow && st.tx_st == sjbfc_pkg::SJBFC_TX_IDLE && !st.hold_sent) begin
			if (want_busy != st.busy_sent || (!st.first_rx && !want_busy && st.rep_cnt == 23'h0)) begin
				next_st.busy_sent = want_busy;
				next_st.tx_sh = {1'b1, want_busy ? sjbfc_pkg::CHAR_XOFF : sjbfc_pkg::CHAR_XON, 1'b0};
				next_st.tx_st = sjbfc_pkg::SJBFC_TX_SHIFT;
				next_st.tx_sub = 4'h0;
				next_st.tx_bit = 4'h0;
				next_st.hold_sent = 1'b1;
				next_st.rep_cnt = 23'(XON_CYC - 1);
			end
		end

		// transmitter, 8N1 plus optional second stop
		if (st.tick && st.tx_st == sjbfc_pkg::SJBFC_TX_SHIFT) begin
			next_st.txd = st.tx_sh[0];
			next_st.tx_sub = st.tx_sub + 4'h1;
			if (st.tx_sub == 4'hF) begin
				next_st.tx_sh  = {1'b1, st.tx_sh[9:1]};
				next_st.tx_bit = st.tx_bit + 4'h1;
				if (st.tx_bit == (stop2 ? 4'hA : 4'h9)) next_st.tx_st = sjbfc_pkg::SJBFC_TX_IDLE;
			end
		end else if (st.tx_st == sjbfc_pkg::SJBFC_TX_IDLE) begin
			next_st.txd = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st           <= '0;
			st.sync_a    <= 2'h3;
			st.sync_b    <= 2'h0;
			st.sync_c    <= 2'h0;
			st.ctrl      <= sjbfc_pkg::CTRL_RESET;
			st.txd       <= 1'b1;
			st.rts       <= 1'b1;
			st.busy_sent <= 1'b1;
			st.rx_st     <= sjbfc_pkg::SJBFC_RX_IDLE;
			st.tx_st     <= sjbfc_pkg::SJBFC_TX_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign s_axi_awready = !st.aw_got;
	assign s_axi_wready  = !st.w_got;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_bresp   = st.bresp;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_rvalid  = st.rvalid;
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = st.rresp;
	assign pins_out.dtr  = st.dtr;
	assign pins_out.rts  = st.rts;
	assign pins_out.txd  = st.txd;

endmodule : sjbfc_top

// file: sjbfc_top_props.sv
/* sjbfc_top_props: port-level checker for sjbfc_top, bound at the foot.
   assumes: one aclk domain, aresetn synchronous and active low. */
`timescale 1ns/10ps
module sjbfc_checker #(
	parameter int unsigned XON_CYC = 200
) (
	// clock and reset
	input wire logic                      aclk,
	input wire logic                      aresetn,
	// axi4-lite
	input wire logic [7:0]                s_axi_awaddr,
	input wire logic                      s_axi_awvalid,
	input wire logic                      s_axi_awready,
	input wire logic                      s_axi_wvalid,
	input wire logic                      s_axi_wready,
	input wire logic [1:0]                s_axi_bresp,
	input wire logic                      s_axi_bvalid,
	input wire logic                      s_axi_bready,
	input wire logic [7:0]                s_axi_araddr,
	input wire logic                      s_axi_arvalid,
	input wire logic                      s_axi_arready,
	input wire logic [31:0]               s_axi_rdata,
	input wire logic [1:0]                s_axi_rresp,
	input wire logic                      s_axi_rvalid,
	input wire logic                      s_axi_rready,
	// serial pins
	input wire sjbfc_pkg::sjbfc_pins_out_s pins_out
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// reset must leave the line idle and RTS high, so no disable here
	a_reset_idle: assert property (disable iff (1'b0) !aresetn |=>
		!s_axi_bvalid && !s_axi_rvalid && pins_out.txd && pins_out.rts)
		else $error("outputs not idle after reset");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("no write answer");
	a_write_unmapped: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready && s_axi_awaddr > 8'h0C |-> ##[1:3] (s_axi_bvalid &&
		s_axi_bresp == sjbfc_pkg::AXI_SLVERR)) else $error("unmapped write accepted");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read answer");
	a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0C
		|=> s_axi_rresp == sjbfc_pkg::AXI_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read accepted");
	a_start_bit: assert property ($fell(pins_out.txd) |=> !pins_out.txd [*8])
		else $error("start bit too short");
	a_error_busy: assert property ($fell(pins_out.rts) |-> ##[0:2] !pins_out.dtr)
		else $error("error without busy");

	// the flow pins must really move during the run, and a read must get SLVERR
	c_busy: cover property ($fell(pins_out.dtr));
	c_char: cover property ($fell(pins_out.txd));
	c_error: cover property ($fell(pins_out.rts));
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == sjbfc_pkg::AXI_SLVERR);
endmodule : sjbfc_checker

bind sjbfc_top sjbfc_checker #(.XON_CYC(XON_CYC)) chk_u (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.pins_out(pins_out));

// file: sjbfc_host_model.sv
/* sjbfc_host_model: host end of the serial link; sends frames on rxd and
   decodes flow characters from txd.
   assumes: 8 data bits, no parity, one stop, same bit time on both ends. */
`timescale 1ns/10ps
module sjbfc_host_model #(
	parameter int unsigned BIT_CYC = 5200
) (
	// clock
	input  wire logic                      aclk,
	// serial pins
	input  wire logic                      txd,
	output sjbfc_pkg::sjbfc_pins_in_s      pins_in,
	// decoded characters
	output logic [7:0]                     rx_char,
	output logic [7:0]                     rx_cnt
);
	logic [7:0] shift;

	initial begin
		pins_in = '{rxd: 1'b1, cts: 1'b1, dsr: 1'b1};
		rx_char = 8'h00;
		rx_cnt = 8'h00;
	end

	// start, data lsb first, stop; line idles at mark level
	task automatic send_byte(input logic [7:0] b);
		for (int i = 0; i < 10; i++) begin
			pins_in.rxd <= (i == 0) ? 1'b0 : ((i == 9) ? 1'b1 : b[(i + 9) % 10 % 8]);
			repeat (BIT_CYC) @(posedge aclk);
		end
	endtask : send_byte

	// samples mid bit, so a skewed device clock still decodes
	always begin
		@(negedge txd);
		repeat (BIT_CYC / 2) @(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge aclk);
			shift[i] = txd;
		end
		repeat (BIT_CYC) @(posedge aclk);
		rx_char <= shift;
		rx_cnt <= rx_cnt + 8'h01;
	end
endmodule : sjbfc_host_model

// file: sjbfc_testbench.sv
/* testbench: drives sjbfc_top over axi4-lite and through the host model,
   compares answers from a queue of expected results.
   assumes: 100 MHz aclk, register map and latencies of the design notes. */
`timescale 1ns/10ps
module testbench;
	localparam int unsigned BIT_CYC = sjbfc_pkg::BAUD_19200_DIV * 16;
	logic                      aclk, aresetn;
	logic [7:0]                awaddr, araddr, rx_char, rx_cnt;
	logic [31:0]               wdata, rdata, seed;
	logic                      awvalid, awready, wvalid, wready, bvalid, bready;
	logic                      arvalid, arready, rvalid, rready;
	logic [1:0]                bresp, rresp;
	sjbfc_pkg::sjbfc_pins_in_s  pins_in;
	sjbfc_pkg::sjbfc_pins_out_s pins_out;
	logic [33:0]               exp_q[$];
	int                        error_cnt = 0, comparisons = 0, cyc_cnt = 0;
	logic [11:0]               ctrl_tab [8] = '{12'h101, 12'h100, 12'h300, 12'h301,
		12'h001, 12'h701, 12'h901, 12'h101};
	logic [2:0]                st_tab [8] = '{3'h7, 3'h7, 3'h5, 3'h7, 3'h5, 3'h4, 3'h4, 3'h7};

	sjbfc_top #(.XON_CYC(200)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.pins_in(pins_in), .pins_out(pins_out));
	sjbfc_host_model #(.BIT_CYC(BIT_CYC)) host_u (.aclk(aclk), .txd(pins_out.txd),
		.pins_in(pins_in), .rx_char(rx_char), .rx_cnt(rx_cnt));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic check(input logic [33:0] got, input logic [33:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task end_sim;
		if (error_cnt == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim

	// answers held off by a low bready or rready are checked once it rises
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		exp_q.push_back({r, 32'h0});
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
	endtask : axi_rd

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// answers are matched in issue order against the oldest note
	always @(posedge aclk) begin
		if (aresetn && bvalid && bready) check({bresp, 32'h0}, exp_q.pop_front());
		if (aresetn && rvalid && rready) check({rresp, rdata}, exp_q.pop_front());
	end

	always @(posedge aclk) begin
		cyc_cnt++;
		if (cyc_cnt == 70000) begin
			error_cnt++;
			end_sim();
		end
	end

	initial begin
		{aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
		{bready, rready} = 2'h3;
		seed = 32'hFC0D;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(sjbfc_pkg::REG_CTRL, {2'h0, 20'h0, sjbfc_pkg::CTRL_RESET});
		axi_rd(sjbfc_pkg::REG_STATUS, {2'h0, 32'h7});
		// answers held back a few cycles, so the hold checks see a stall
		rready <= 1'b0;
		seed = lfsr(seed);
		axi_rd(8'h10 + {2'h0, seed[5:2], 2'h0}, {sjbfc_pkg::AXI_SLVERR, 32'h0});
		repeat (2) @(posedge aclk);
		rready <= 1'b1;
		bready <= 1'b0;
		seed = lfsr(seed);
		axi_wr(8'h10 + {2'h0, seed[9:6], 2'h0}, seed, sjbfc_pkg::AXI_SLVERR);
		repeat (2) @(posedge aclk);
		bready <= 1'b1;
		@(posedge aclk);
		// mode, printing, off-line, error and head states against both flow pins
		for (int i = 0; i < 8; i++) begin
			axi_wr(sjbfc_pkg::REG_CTRL, {20'h0, ctrl_tab[i]}, sjbfc_pkg::AXI_OKAY);
			repeat (3) @(posedge aclk);
			axi_rd(sjbfc_pkg::REG_STATUS, {2'h0, 29'h0, st_tab[i]});
			check({32'h0, pins_out.dtr, pins_out.rts}, {32'h0, st_tab[i][1:0]});
		end
		// character flow, queued jobs, fastest rate
		axi_wr(sjbfc_pkg::REG_CTRL, 32'h10F, sjbfc_pkg::AXI_OKAY);
		fork
			host_u.send_byte(8'h02);
			for (int n = 0; n < 60000 && rx_cnt == 8'h00; n++) @(posedge aclk);
		join
		check({26'h0, rx_char}, {26'h0, sjbfc_pkg::CHAR_XON});
		repeat (20) @(posedge aclk);
		axi_rd(sjbfc_pkg::REG_LEVEL, {2'h0, 32'h1});
		axi_rd(sjbfc_pkg::REG_RXDATA, {2'h0, 32'h102});
		repeat (2) @(posedge aclk);
		axi_rd(sjbfc_pkg::REG_LEVEL, {2'h0, 32'h0});
		end_sim();
	end
endmodule : testbench
